// ==== rtl/uimc_pkg.sv ====
// package: register map, field layout and timing constants for uimc
`default_nettype none

package uimc_pkg;

   // register data width and APB address width
   localparam int          UIMC_DW       = 16;
   localparam int          UIMC_ADDR_W   = 18;

   // register indices; byte address is four times the index
   localparam logic [15:0] UIMC_IDX_EN_A   = 16'h4046;
   localparam logic [15:0] UIMC_IDX_EN_B   = 16'h4048;
   localparam logic [15:0] UIMC_IDX_STAT_A = 16'h404a;
   localparam logic [15:0] UIMC_IDX_STAT_B = 16'h404c;
   localparam logic [15:0] UIMC_IDX_MSK_A  = 16'h404e;
   localparam logic [15:0] UIMC_IDX_MSK_B  = 16'h4050;
   localparam logic [15:0] UIMC_IDX_SRST   = 16'h4052;
   localparam logic [15:0] UIMC_IDX_WS     = 16'h4054;

   localparam logic [17:0] UIMC_ADR_EN_A   = {UIMC_IDX_EN_A, 2'b00};
   localparam logic [17:0] UIMC_ADR_EN_B   = {UIMC_IDX_EN_B, 2'b00};
   localparam logic [17:0] UIMC_ADR_STAT_A = {UIMC_IDX_STAT_A, 2'b00};
   localparam logic [17:0] UIMC_ADR_STAT_B = {UIMC_IDX_STAT_B, 2'b00};
   localparam logic [17:0] UIMC_ADR_MSK_A  = {UIMC_IDX_MSK_A, 2'b00};
   localparam logic [17:0] UIMC_ADR_MSK_B  = {UIMC_IDX_MSK_B, 2'b00};
   localparam logic [17:0] UIMC_ADR_SRST   = {UIMC_IDX_SRST, 2'b00};
   localparam logic [17:0] UIMC_ADR_WS     = {UIMC_IDX_WS, 2'b00};

   // event bit positions, bank a
   localparam int          UIMC_BIT_HOST_CONN = 6;
   localparam int          UIMC_BIT_BUS_RESET = 1;
   // event bit positions, bank b
   localparam int          UIMC_BIT_HOST_DISC = 6;
   localparam int          UIMC_BIT_DEV_CFG   = 4;
   localparam int          UIMC_BIT_REG_INT   = 0;

   // implemented bits per bank; all others read zero
   localparam logic [15:0] UIMC_VALID_A = 16'h0042;
   localparam logic [15:0] UIMC_VALID_B = 16'h0051;

   // soft reset key and wait-state field
   localparam logic [7:0]  UIMC_RST_KEY     = 8'ha4;
   localparam int          UIMC_KEY_W       = 8;
   localparam int          UIMC_WS_W        = 2;
   localparam logic [1:0]  UIMC_WS_REQUIRED = 2'h1;

   // values after reset
   localparam logic [15:0] UIMC_REG_RST = 16'h0000;
   localparam logic [1:0]  UIMC_WS_RST  = 2'h0;
   localparam logic [31:0] UIMC_RD_RST  = 32'h0000_0000;

   // soft reset pulse length, least time rounded up
   localparam int          UIMC_CLK_NS   = 10;
   localparam int          UIMC_SRST_NS  = 40;
   localparam int          UIMC_SRST_CYC =
      (UIMC_SRST_NS + UIMC_CLK_NS - 1) / UIMC_CLK_NS;

endpackage : uimc_pkg

`default_nettype wire

// ==== rtl/uimc_stat_bank.sv ====
// one bank of sticky status/clear, enable and masked status bits
`default_nettype none

module uimc_stat_bank
   import uimc_pkg::*;
#(
   parameter logic [15:0] VALID = UIMC_VALID_A
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          soft_rst,
   input  wire logic [15:0]   evt,
   input  wire logic          clr_we,
   input  wire logic          en_we,
   input  wire logic [15:0]   wdata,
   output logic      [15:0]   status,
   output logic      [15:0]   enable,
   output logic      [15:0]   masked
);

   typedef struct packed {
      logic [15:0] stat;
      logic [15:0] en;
   } uimc_bank_t;

   uimc_bank_t st_r;
   uimc_bank_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (clr_we) begin
         st_nxt.stat = st_r.stat & ~wdata;
      end
      // a new event outranks a clear in the same cycle
      st_nxt.stat = (st_nxt.stat | evt) & VALID;
      if (en_we) begin
         st_nxt.en = wdata & VALID;
      end
      if (soft_rst) begin
         st_nxt.stat = UIMC_REG_RST;
         st_nxt.en   = UIMC_REG_RST;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= {UIMC_REG_RST, UIMC_REG_RST};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign status = st_r.stat;
   assign enable = st_r.en;
   assign masked = st_r.stat & st_r.en & VALID;

endmodule : uimc_stat_bank

`default_nettype wire

// ==== rtl/uimc_rst_gen.sv ====
// keyed software reset: stretches a key match into a reset pulse
`default_nettype none

module uimc_rst_gen
   import uimc_pkg::*;
#(
   parameter int CYC = UIMC_SRST_CYC
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  key_we,
   input  wire logic [UIMC_KEY_W-1:0] key,
   output logic                       usb_soft_rst
);

   localparam int CW = $clog2(CYC + 1);
   localparam logic [CW-1:0] CNT_LOAD = CW'(CYC);
   localparam logic [CW-1:0] CNT_ZERO = '0;

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          act;
   } uimc_rst_t;

   uimc_rst_t st_r;
   uimc_rst_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (st_r.cnt != CNT_ZERO) begin
         st_nxt.cnt = st_r.cnt - CW'(1);
      end
      // only the exact key arms the pulse; any other value is dropped
      if (key_we && key == UIMC_RST_KEY) begin
         st_nxt.cnt = CNT_LOAD;
      end
      st_nxt.act = (st_nxt.cnt != CNT_ZERO);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign usb_soft_rst = st_r.act;

endmodule : uimc_rst_gen

`default_nettype wire

// ==== rtl/uimc_top.sv ====
// usb interrupt masking, keyed soft reset and wait-state control, APB slave
//
// Chosen here: register access over APB.
`default_nettype none

module uimc_top
   import uimc_pkg::*;
#(
   parameter int ADDR_W   = UIMC_ADDR_W,
   parameter int SRST_CYC = UIMC_SRST_CYC
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              usb_host_conn_evt,
   input  wire logic              bus_reset_event,
   input  wire logic              usb_host_disc_evt,
   input  wire logic              usb_dev_cfg_evt,
   input  wire logic              usb_reg_int_evt,
   output logic                   usb_soft_rst,
   output logic      [1:0]        usb_wait_states,
   output logic                   irq
);

   typedef struct packed {
      logic [31:0]          rdata;
      logic [UIMC_WS_W-1:0] ws;
      logic [UIMC_WS_W-1:0] ws_cnt;
      logic                 irq;
   } uimc_top_t;

   uimc_top_t st_r;
   uimc_top_t st_nxt;

   // address decode
   logic hit_en_a;
   logic hit_en_b;
   logic hit_stat_a;
   logic hit_stat_b;
   logic hit_msk_a;
   logic hit_msk_b;
   logic hit_srst;
   logic hit_ws;
   logic hit_any;

   // bus phase
   logic acc;
   logic done;
   logic wr_done;

   // bank wiring
   logic [15:0] evt_a;
   logic [15:0] evt_b;
   logic [15:0] status_a;
   logic [15:0] status_b;
   logic [15:0] enable_a;
   logic [15:0] enable_b;
   logic [15:0] masked_a;
   logic [15:0] masked_b;
   logic [15:0] wdata16;
   logic [15:0] rd_mux;

   assign wdata16 = pwdata[15:0];

   always_comb begin
      hit_en_a   = 1'b0;
      hit_en_b   = 1'b0;
      hit_stat_a = 1'b0;
      hit_stat_b = 1'b0;
      hit_msk_a  = 1'b0;
      hit_msk_b  = 1'b0;
      hit_srst   = 1'b0;
      hit_ws     = 1'b0;
      if (paddr == ADDR_W'(UIMC_ADR_EN_A)) begin
         hit_en_a = 1'b1;
      end else if (paddr == ADDR_W'(UIMC_ADR_EN_B)) begin
         hit_en_b = 1'b1;
      end else if (paddr == ADDR_W'(UIMC_ADR_STAT_A)) begin
         hit_stat_a = 1'b1;
      end else if (paddr == ADDR_W'(UIMC_ADR_STAT_B)) begin
         hit_stat_b = 1'b1;
      end else if (paddr == ADDR_W'(UIMC_ADR_MSK_A)) begin
         hit_msk_a = 1'b1;
      end else if (paddr == ADDR_W'(UIMC_ADR_MSK_B)) begin
         hit_msk_b = 1'b1;
      end else if (paddr == ADDR_W'(UIMC_ADR_SRST)) begin
         hit_srst = 1'b1;
      end else if (paddr == ADDR_W'(UIMC_ADR_WS)) begin
         hit_ws = 1'b1;
      end
      hit_any = hit_en_a | hit_en_b | hit_stat_a | hit_stat_b |
                hit_msk_a | hit_msk_b | hit_srst | hit_ws;
   end

   // access phase ends once the programmed wait states have elapsed;
   // >= keeps a transfer from hanging if the field changes mid-access
   assign acc     = psel & penable;
   assign done    = acc & (st_r.ws_cnt >= st_r.ws);
   assign wr_done = done & pwrite;

   assign pready  = done;
   assign pslverr = done & ~hit_any;

   // read mux; write-only key register reads zero
   always_comb begin
      rd_mux = UIMC_REG_RST;
      if (hit_en_a) begin
         rd_mux = enable_a;
      end else if (hit_en_b) begin
         rd_mux = enable_b;
      end else if (hit_stat_a) begin
         rd_mux = status_a;
      end else if (hit_stat_b) begin
         rd_mux = status_b;
      end else if (hit_msk_a) begin
         rd_mux = masked_a;
      end else if (hit_msk_b) begin
         rd_mux = masked_b;
      end else if (hit_ws) begin
         rd_mux = {{(16 - UIMC_WS_W){1'b0}}, st_r.ws};
      end
   end

   // event vectors in register layout
   always_comb begin
      evt_a = UIMC_REG_RST;
      evt_b = UIMC_REG_RST;
      evt_a[UIMC_BIT_HOST_CONN] = usb_host_conn_evt;
      evt_a[UIMC_BIT_BUS_RESET] = bus_reset_event;
      evt_b[UIMC_BIT_HOST_DISC] = usb_host_disc_evt;
      evt_b[UIMC_BIT_DEV_CFG]   = usb_dev_cfg_evt;
      evt_b[UIMC_BIT_REG_INT]   = usb_reg_int_evt;
   end

   uimc_stat_bank #(
      .VALID    (UIMC_VALID_A)
   ) u_bank_a (
      .pclk     (pclk),
      .presetn  (presetn),
      .soft_rst (usb_soft_rst),
      .evt      (evt_a),
      .clr_we   (wr_done & hit_stat_a),
      .en_we    (wr_done & hit_en_a),
      .wdata    (wdata16),
      .status   (status_a),
      .enable   (enable_a),
      .masked   (masked_a)
   );

   uimc_stat_bank #(
      .VALID    (UIMC_VALID_B)
   ) u_bank_b (
      .pclk     (pclk),
      .presetn  (presetn),
      .soft_rst (usb_soft_rst),
      .evt      (evt_b),
      .clr_we   (wr_done & hit_stat_b),
      .en_we    (wr_done & hit_en_b),
      .wdata    (wdata16),
      .status   (status_b),
      .enable   (enable_b),
      .masked   (masked_b)
   );

   uimc_rst_gen #(
      .CYC          (SRST_CYC)
   ) u_rst_gen (
      .pclk         (pclk),
      .presetn      (presetn),
      .key_we       (wr_done & hit_srst),
      .key          (pwdata[UIMC_KEY_W-1:0]),
      .usb_soft_rst (usb_soft_rst)
   );

   always_comb begin
      st_nxt = st_r;
      // wait-state counter runs only inside an access phase
      if (acc && !done) begin
         st_nxt.ws_cnt = st_r.ws_cnt + UIMC_WS_W'(1);
      end else begin
         st_nxt.ws_cnt = UIMC_WS_RST;
      end
      // read data is sampled every selected cycle before the answer;
      // what software sees is the state one cycle before pready
      if (psel && !done) begin
         st_nxt.rdata = {16'h0000, rd_mux};
      end
      // no check of the written value: 01 is software's duty
      if (wr_done && hit_ws) begin
         st_nxt.ws = pwdata[UIMC_WS_W-1:0];
      end
      st_nxt.irq = |(masked_a | masked_b);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r.rdata  <= UIMC_RD_RST;
         st_r.ws     <= UIMC_WS_RST;
         st_r.ws_cnt <= UIMC_WS_RST;
         st_r.irq    <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata          = st_r.rdata;
   assign usb_wait_states = st_r.ws;
   assign irq             = st_r.irq;

endmodule : uimc_top

`default_nettype wire

// ==== tb/uimc_chk_sva.sv ====
// port-level assertions for the uimc apb slave
`default_nettype none

module uimc_chk_sva
   import uimc_pkg::*;
#(
   parameter int ADDR_W   = UIMC_ADDR_W,
   parameter int SRST_CYC = UIMC_SRST_CYC
) (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              usb_soft_rst,
   input wire logic [1:0]        usb_wait_states,
   input wire logic              irq
);
   logic       done;
   logic [7:0] hi_r;

   assign done = psel && penable && pready;

   // counts cycles the soft reset has already been high
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         hi_r <= 8'h0;
      else
         hi_r <= usb_soft_rst ? hi_r + 8'h1 : 8'h0;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence one_wait_s; !pready ##1 pready; endsequence
   sequence key_wr_s; done && pwrite && paddr == UIMC_ADR_SRST; endsequence
   sequence ws_wr_s; done && pwrite && paddr == UIMC_ADR_WS; endsequence

   hi_zero_a: assert property (prdata[31:16] == 16'h0)
      else $error("upper read data not zero");
   err_ready_a: assert property (pslverr |-> pready && psel && penable)
      else $error("error response outside access");
   no_wait_a: assert property ($rose(penable) && psel &&
      usb_wait_states == 2'h0 |-> pready)
      else $error("zero wait states not honoured");
   one_wait_a: assert property ($rose(penable) && psel &&
      usb_wait_states == 2'h1 |-> one_wait_s)
      else $error("one wait state not honoured");
   ws_write_a: assert property (ws_wr_s |=>
      usb_wait_states == $past(pwdata[1:0]))
      else $error("wait state write lost");
   ws_hold_a: assert property (!(done && pwrite && paddr == UIMC_ADR_WS)
      |=> $stable(usb_wait_states))
      else $error("wait state changed without write");
   key_fire_a: assert property (key_wr_s ##0
      pwdata[7:0] == UIMC_RST_KEY |=> usb_soft_rst)
      else $error("key write did not reset");
   bad_key_a: assert property (key_wr_s ##0 pwdata[7:0] != UIMC_RST_KEY
      && !usb_soft_rst |=> !usb_soft_rst)
      else $error("wrong key caused reset");
   srst_len_a: assert property ($fell(usb_soft_rst) |->
      $past(hi_r) == SRST_CYC - 1)
      else $error("soft reset length wrong");
   srst_irq_a: assert property ($rose(usb_soft_rst) |-> ##2 !irq)
      else $error("irq survived soft reset");
   rsvd_a_a: assert property (done && !pwrite && paddr == UIMC_ADR_MSK_A
      |-> (prdata[15:0] & ~UIMC_VALID_A) == 16'h0)
      else $error("reserved masked bit set");
   rsvd_b_a: assert property (done && !pwrite && paddr == UIMC_ADR_MSK_B
      |-> (prdata[15:0] & ~UIMC_VALID_B) == 16'h0)
      else $error("reserved masked bit set");
endmodule : uimc_chk_sva

bind uimc_top uimc_chk_sva #(.ADDR_W(ADDR_W), .SRST_CYC(SRST_CYC)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .usb_soft_rst(usb_soft_rst),
   .usb_wait_states(usb_wait_states), .irq(irq));

`default_nettype wire

// ==== tb/test_usb_irq_mask_and_control.sv ====
// self-checking bench for uimc_top over apb
`default_nettype none

module test_usb_irq_mask_and_control import uimc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        irq, usb_soft_rst, e, irq_s, srst_s;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [1:0]  usb_wait_states, w;
   logic [4:0]  ev;
   int          err_total, checks, nc;
   // key only in upper byte must not count
   logic [31:0] bad [4] = '{32'h00a5, 32'ha400, 32'h0000, 32'h00a6};

   uimc_top u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .usb_host_conn_evt(ev[4]),
      .bus_reset_event(ev[3]), .usb_host_disc_evt(ev[2]),
      .usb_dev_cfg_evt(ev[1]), .usb_reg_int_evt(ev[0]),
      .usb_soft_rst(usb_soft_rst), .usb_wait_states(usb_wait_states),
      .irq(irq));

   always #5 pclk = ~pclk;

   task automatic end_of_test();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checks++;
      if (s !== x) begin
         err_total++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask : chk

   // entered just after an edge; pready sampled at each rising edge,
   // returns at the completing edge with the request still standing
   task automatic apb(input logic wr, input logic [17:0] a,
                      input logic [31:0] d);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      nc = n;
      q  = prdata;
      e  = pslverr;
      w  = usb_wait_states;
      if (pready !== 1'b1) begin
         err_total++;
         end_of_test();
      end
   endtask : apb

   task automatic rd_chk(input logic [17:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q, x);
   endtask : rd_chk

   task automatic idle(input logic [4:0] m);
      psel    <= 1'b0;
      penable <= 1'b0;
      ev      <= m;
      @(posedge pclk);
      ev      <= 5'h0;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      irq_s  = irq;
      srst_s = usb_soft_rst;
      @(posedge pclk);
   endtask : idle

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 18'h0;
      pwdata = 32'h0;
      ev = 5'h0;
      err_total = 0;
      checks = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk(UIMC_ADR_MSK_A, 32'h0);
      rd_chk(UIMC_ADR_MSK_B, 32'h0);
      rd_chk(UIMC_ADR_SRST, 32'h0);
      for (int i = 3; i >= 0; i--) begin
         apb(1'b1, UIMC_ADR_WS, 32'hffff_fffc | 32'(i));
         rd_chk(UIMC_ADR_WS, 32'(i));
         chk({30'h0, w}, 32'(i));
         chk(32'(nc), 32'(i + 1));
      end
      apb(1'b1, UIMC_ADR_WS, 32'h1);
      apb(1'b1, UIMC_ADR_STAT_A, 32'hffff);
      apb(1'b1, UIMC_ADR_STAT_B, 32'hffff);
      apb(1'b1, UIMC_ADR_EN_A, 32'hffff);
      apb(1'b1, UIMC_ADR_EN_B, 32'hffff);
      idle(5'h1f);
      chk({31'h0, irq_s}, 32'h1);
      rd_chk(UIMC_ADR_MSK_A, 32'h42);
      rd_chk(UIMC_ADR_MSK_B, 32'h51);
      apb(1'b1, UIMC_ADR_MSK_A, 32'h0);
      rd_chk(UIMC_ADR_MSK_A, 32'h42);
      apb(1'b1, UIMC_ADR_EN_A, 32'hffbf);
      rd_chk(UIMC_ADR_MSK_A, 32'h02);
      rd_chk(UIMC_ADR_STAT_A, 32'h42);
      apb(1'b1, UIMC_ADR_STAT_A, 32'h2);
      rd_chk(UIMC_ADR_STAT_A, 32'h40);
      rd_chk(UIMC_ADR_MSK_A, 32'h0);
      apb(1'b1, UIMC_ADR_STAT_B, 32'h0);
      rd_chk(UIMC_ADR_STAT_B, 32'h51);
      apb(1'b1, UIMC_ADR_EN_B, 32'h0);
      idle(5'h0);
      chk({31'h0, irq_s}, 32'h0);
      foreach (bad[i]) apb(1'b1, UIMC_ADR_SRST, bad[i]);
      idle(5'h0);
      chk({31'h0, srst_s}, 32'h0);
      rd_chk(UIMC_ADR_STAT_B, 32'h51);
      apb(1'b1, UIMC_ADR_EN_B, 32'h1);
      idle(5'h0);
      chk({31'h0, irq_s}, 32'h1);
      apb(1'b1, UIMC_ADR_SRST, 32'hffa4);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
      chk({31'h0, usb_soft_rst}, 32'h1);
      @(posedge pclk);
      rd_chk(UIMC_ADR_STAT_B, 32'h0);
      rd_chk(UIMC_ADR_EN_B, 32'h0);
      rd_chk(UIMC_ADR_WS, 32'h1);
      idle(5'h0);
      chk({31'h0, irq_s}, 32'h0);
      rd_chk(18'h0, 32'h0);
      chk({31'h0, e}, 32'h1);
      end_of_test();
   end
endmodule : test_usb_irq_mask_and_control

`default_nettype wire
